// [verilog/uio_pkg.sv]
// constants and types shared by the user i/o port and its routing logic
`default_nettype none
package uio_pkg;
  localparam int         UIO_PINS       = 8;
  localparam int         UIO_SYNC_STAGES = 2;
  // special function register offsets
  localparam logic [7:0]  UIO_SFR_DATA   = 8'h90;
  localparam logic [7:0]  UIO_SFR_DIR    = 8'h91;
  // external-space routing control registers
  localparam logic [15:0] UIO_XR_ROUTE_A = 16'hff90;
  localparam logic [15:0] UIO_XR_ROUTE_B = 16'hff91;
  localparam logic [15:0] UIO_XR_ROUTE_C = 16'hff92;
  localparam logic [15:0] UIO_XR_ROUTE_D = 16'hff93;
  // reset values
  localparam logic [7:0]  UIO_DIR_RST    = 8'hff;
  localparam logic [7:0]  UIO_DATA_RST   = 8'hff;
  localparam logic [7:0]  UIO_ROUTE_RST  = 8'h00;
  // routing word layout: low pin in 2:0, high pin in 6:4, 7 and 3 unused
  localparam logic [7:0]  UIO_ROUTE_MASK = 8'h77;
  localparam int          UIO_SEL_W      = 3;
  localparam int          UIO_SEL_LO_LSB = 0;
  localparam int          UIO_SEL_HI_LSB = 4;

  typedef enum logic [UIO_SEL_W-1:0] {
    UIO_SEL_NONE0,
    UIO_SEL_NONE1,
    UIO_SEL_TMR0,
    UIO_SEL_TMR1,
    UIO_SEL_IRQ0_POS,
    UIO_SEL_IRQ1_POS,
    UIO_SEL_IRQ0_NEG,
    UIO_SEL_IRQ1_NEG
  } uio_sel_t;
endpackage
`default_nettype wire

// [verilog/uio_route_if.sv]
// bundle between the port registers and the resource routing logic
`default_nettype none
interface uio_route_if;
  import uio_pkg::*;
  logic [UIO_PINS-1:0]                pin_lvl;
  logic [UIO_PINS-1:0][UIO_SEL_W-1:0] sel;
  logic [1:0]                         irq_type;
  logic                               tmr0;
  logic                               tmr1;
  logic                               irq0;
  logic                               irq1;
  modport ctl (output pin_lvl, sel, irq_type,
               input  tmr0, tmr1, irq0, irq1);
  modport rt  (input  pin_lvl, sel, irq_type,
               output tmr0, tmr1, irq0, irq1);
endinterface
`default_nettype wire

// [verilog/uio_route.sv]
// per-pin resource selection, or-merge and interrupt edge/level shaping
`default_nettype none
module uio_route
  import uio_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  uio_route_if.rt   rif
);
  logic [UIO_PINS-1:0] hit_t0;
  logic [UIO_PINS-1:0] hit_t1;
  logic [UIO_PINS-1:0] hit_i0;
  logic [UIO_PINS-1:0] hit_i1;
  logic                lvl_i0;
  logic                lvl_i1;
  logic                prev_i0;
  logic                prev_i1;

  // each pin contributes to at most one resource; codes 0 and 1 attach none
  for (genvar i = 0; i < UIO_PINS; i++) begin : g_pin
    assign hit_t0[i] = (rif.sel[i] == UIO_SEL_TMR0) & rif.pin_lvl[i];
    assign hit_t1[i] = (rif.sel[i] == UIO_SEL_TMR1) & rif.pin_lvl[i];
    assign hit_i0[i] = ((rif.sel[i] == UIO_SEL_IRQ0_POS) & rif.pin_lvl[i])
                     | ((rif.sel[i] == UIO_SEL_IRQ0_NEG) & ~rif.pin_lvl[i]);
    assign hit_i1[i] = ((rif.sel[i] == UIO_SEL_IRQ1_POS) & rif.pin_lvl[i])
                     | ((rif.sel[i] == UIO_SEL_IRQ1_NEG) & ~rif.pin_lvl[i]);
  end

  // shared resources see the or of every pin routed to them
  assign rif.tmr0 = |hit_t0;
  assign rif.tmr1 = |hit_t1;
  assign lvl_i0   = |hit_i0;
  assign lvl_i1   = |hit_i1;

  // previous merged level, for edge mode
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prev_i0 <= 1'b0;
      prev_i1 <= 1'b0;
    end else begin
      prev_i0 <= lvl_i0;
      prev_i1 <= lvl_i1;
    end
  end

  // type bit set: one-cycle pulse on the active edge; clear: follow level
  assign rif.irq0 = rif.irq_type[0] ? (lvl_i0 & ~prev_i0) : lvl_i0;
  assign rif.irq1 = rif.irq_type[1] ? (lvl_i1 & ~prev_i1) : lvl_i1;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_T0_MERGE: assert property (
    (rif.sel[0] == UIO_SEL_TMR0 && rif.pin_lvl[0]) |-> rif.tmr0)
    else $error("timer 0 input misses pin 0");
  AST_NONE_ATTACH: assert property (
    (rif.sel == '0) |-> !(rif.tmr0 || rif.tmr1 || rif.irq0 || rif.irq1))
    else $error("resource driven with no pin routed");
  AST_NEG_LEVEL: assert property (
    (rif.sel[1] == UIO_SEL_IRQ1_NEG && !rif.pin_lvl[1] && !rif.irq_type[1])
    |-> rif.irq1)
    else $error("inverted level route not seen on interrupt 1");
  AST_EDGE_PULSE: assert property (
    (rif.irq_type[0] && rif.irq0) |=> !rif.irq0 || !rif.irq_type[0])
    else $error("edge mode interrupt lasted more than one cycle");
  AST_EDGE_RISE: assert property (
    (rif.irq_type[1] && lvl_i1 && !$past(lvl_i1)) |-> rif.irq1)
    else $error("edge mode interrupt 1 missed a rising edge");

  COV_T1_ROUTED: cover property (rif.tmr1);
  COV_IRQ0_EDGE: cover property (rif.irq_type[0] && rif.irq0);
endmodule
`default_nettype wire

// [verilog/uio_port.sv]
// eight-pin user i/o port with direction, data, pull-up and resource routing
// Operation
// - after reset all eight pins are inputs until software sets direction.
// - each direction bit controls its own pin, 0 output and 1 input.
// - data reads return pin levels and written data drives output pins.
// - pins are pulled up from reset until the first direction write.
// - four routing registers each hold two 3-bit select words, 2:0 and 6:4.
// - select 0 or 1 attaches nothing, 2 timer 0 input, 3 timer 1 input.
// - selects 4 and 5 route true to interrupt 0/1, 6 and 7 inverted.
// - pins selecting one resource are or-ed together.
// - edge or level handling of a routed interrupt follows its type bit.
// - routing registers reset to zero and sit at consecutive addresses.
// - interrupts 0 and 1 each have a type bit in the timer control reg.
`default_nettype none
module uio_port
  import uio_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic                sfr_wr,
  input  wire logic                sfr_rd,
  input  wire logic [7:0]          sfr_wdata,
  output logic      [7:0]          sfr_rdata,
  input  wire logic [15:0]         xram_addr,
  input  wire logic                xram_wr,
  input  wire logic                xram_rd,
  input  wire logic [7:0]          xram_wdata,
  output logic      [7:0]          xram_rdata,
  input  wire logic                irq0_type_bit,
  input  wire logic                irq1_type_bit,
  output logic                     timer0_gate_clock_in,
  output logic                     timer1_gate_clock_in,
  output logic                     ext_irq0,
  output logic                     ext_irq1,
  input  wire logic [UIO_PINS-1:0] user_pin_in,
  output logic      [UIO_PINS-1:0] user_pin_out,
  output logic      [UIO_PINS-1:0] user_pin_oe,
  output logic                     user_pin_pullup
);
  localparam int NROUTE = UIO_PINS / 2;

  logic [UIO_PINS-1:0] pin_data;
  logic [UIO_PINS-1:0] pin_direction;
  logic [7:0]          route [NROUTE];
  logic [UIO_PINS-1:0] sync_a;
  logic [UIO_PINS-1:0] pin_sync;
  logic                pull_on;
  logic                wr_data;
  logic                wr_dir;
  logic [NROUTE-1:0]   wr_route;
  logic [NROUTE-1:0]   hit_route;
  logic [7:0]          next_sfr_rdata;
  logic [7:0]          next_xram_rdata;
  logic [7:0]          route_rd;

  uio_route_if rif ();

  // register decode
  assign wr_data = sfr_wr && (sfr_addr == UIO_SFR_DATA);
  assign wr_dir  = sfr_wr && (sfr_addr == UIO_SFR_DIR);

  // routing registers occupy four consecutive external addresses
  for (genvar r = 0; r < NROUTE; r++) begin : g_route
    assign hit_route[r] = (xram_addr == UIO_XR_ROUTE_A + 16'(r));
    assign wr_route[r]  = xram_wr && hit_route[r];
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        route[r] <= UIO_ROUTE_RST;
      end else if (wr_route[r]) begin
        route[r] <= xram_wdata & UIO_ROUTE_MASK;
      end
    end
    // low pin of the pair in 2:0, high pin in 6:4
    assign rif.sel[2*r]   = route[r][UIO_SEL_LO_LSB +: UIO_SEL_W];
    assign rif.sel[2*r+1] = route[r][UIO_SEL_HI_LSB +: UIO_SEL_W];
  end

  // two-stage synchroniser; only the second stage is used anywhere
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync_a   <= '0;
      pin_sync <= '0;
    end else begin
      sync_a   <= user_pin_in;
      pin_sync <= sync_a;
    end
  end

  // data, direction and pull-up state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_data      <= UIO_DATA_RST;
      pin_direction <= UIO_DIR_RST;
      pull_on       <= 1'b1;
    end else begin
      if (wr_data) pin_data <= sfr_wdata;
      if (wr_dir) begin
        pin_direction <= sfr_wdata;
        pull_on       <= 1'b0;
      end
    end
  end

  // pull-up is released by any direction write, even one of all ones
  assign user_pin_pullup = pull_on;
  assign user_pin_oe     = ~pin_direction;
  assign user_pin_out    = pin_data;

  // read muxes; unmapped addresses return zero
  always_comb begin
    route_rd = 8'h00;
    for (int r = 0; r < NROUTE; r++) begin
      if (hit_route[r]) route_rd = route[r];
    end
  end
  assign next_sfr_rdata = !sfr_rd ? sfr_rdata :
                          (sfr_addr == UIO_SFR_DATA) ? pin_sync :
                          (sfr_addr == UIO_SFR_DIR) ? pin_direction :
                          8'h00;
  assign next_xram_rdata = xram_rd ? route_rd : xram_rdata;

  // read data is held until the next read of its bus
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sfr_rdata  <= 8'h00;
      xram_rdata <= 8'h00;
    end else begin
      sfr_rdata  <= next_sfr_rdata;
      xram_rdata <= next_xram_rdata;
    end
  end

  // routing uses synchronised levels; edge/level comes from the type bits
  assign rif.pin_lvl  = pin_sync;
  assign rif.irq_type = {irq1_type_bit, irq0_type_bit};

  uio_route u_route (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .rif      (rif.rt)
  );

  assign timer0_gate_clock_in = rif.tmr0;
  assign timer1_gate_clock_in = rif.tmr1;
  assign ext_irq0             = rif.irq0;
  assign ext_irq1             = rif.irq1;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_DIR_RESET: assert property (
    !$past(rst_n) |-> (user_pin_oe == '0 && user_pin_pullup))
    else $error("pins not inputs with pull-up after reset");
  AST_DIR_WRITE: assert property (
    wr_dir |=> user_pin_oe == ~$past(sfr_wdata))
    else $error("direction write not applied per bit");
  AST_DATA_DRIVE: assert property (
    wr_data |=> user_pin_out == $past(sfr_wdata))
    else $error("written data not driven");
  AST_DATA_READ: assert property (
    (sfr_rd && sfr_addr == UIO_SFR_DATA) |=>
      sfr_rdata == $past(user_pin_in, 3))
    else $error("data read not three cycles behind pins");
  AST_PULLUP_HOLD: assert property (
    (user_pin_pullup && !wr_dir) |=> user_pin_pullup)
    else $error("pull-up dropped without direction write");
  AST_PULLUP_OFF: assert property (
    wr_dir |=> !user_pin_pullup [*2])
    else $error("pull-up still on after direction write");
  AST_ROUTE_RESET: assert property (
    !$past(rst_n) |-> (!timer0_gate_clock_in && !timer1_gate_clock_in
                       && !ext_irq0 && !ext_irq1))
    else $error("resource attached right after reset");
  AST_ROUTE_READBACK: assert property (
    (xram_wr && xram_addr == UIO_XR_ROUTE_B) ##1 !xram_wr ##1
      (xram_rd && xram_addr == UIO_XR_ROUTE_B && !xram_wr) |=>
      xram_rdata == ($past(xram_wdata, 3) & UIO_ROUTE_MASK))
    else $error("routing register readback wrong");

  COV_DIR_WRITE: cover property (wr_dir);
  COV_PIN_READ: cover property (sfr_rd && sfr_addr == UIO_SFR_DATA);
  COV_IRQ1: cover property (ext_irq1);
endmodule
`default_nettype wire

// [verif/uio_pins_model.sv]
// board-side model of the eight user pins
`default_nettype none
module uio_pins_model
  import uio_pkg::*;
(
  input  wire logic [UIO_PINS-1:0] pin_out,
  input  wire logic [UIO_PINS-1:0] pin_oe,
  input  wire logic                pull_en,
  input  wire logic [UIO_PINS-1:0] ext_val,
  input  wire logic [UIO_PINS-1:0] ext_en,
  output logic      [UIO_PINS-1:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // port drive wins, then board drive; a pin left open floats unless pulled
  // up, and a float shows the inverse of the last board value
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en
                    & (pull_en ? {UIO_PINS{1'b1}} : ~ext_val));
endmodule
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the user i/o port
`default_nettype none
module tb
  import uio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [15:0] xram_addr = 16'h0000;
  logic       xram_wr = 1'b0;
  logic       xram_rd = 1'b0;
  logic [7:0] xram_wdata = 8'h00;
  logic [7:0] xram_rdata;
  logic       it0 = 1'b0;
  logic       it1 = 1'b0;
  logic       t0, t1, i0, i1, pull_on;
  logic [7:0] pin_in, pin_out, pin_oe;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] ext_en = 8'h00;
  int         error_cnt = 0;
  int         tests_run = 0;

  uio_port dut (.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .xram_addr(xram_addr), .xram_wr(xram_wr),
    .xram_rd(xram_rd), .xram_wdata(xram_wdata), .xram_rdata(xram_rdata),
    .irq0_type_bit(it0), .irq1_type_bit(it1), .timer0_gate_clock_in(t0),
    .timer1_gate_clock_in(t1), .ext_irq0(i0), .ext_irq1(i1),
    .user_pin_in(pin_in), .user_pin_out(pin_out), .user_pin_oe(pin_oe),
    .user_pin_pullup(pull_on));
  uio_pins_model board (.pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_on),
    .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_in));

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // settle past the edge so registered outputs have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_wr <= wr;
    sfr_rd <= !wr;
    sfr_addr <= a;
    sfr_wdata <= d;
    // strobe is sampled high at this edge and dropped by the same nba
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    #1;
  endtask

  task automatic xr(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    xram_wr <= wr;
    xram_rd <= !wr;
    xram_addr <= a;
    xram_wdata <= d;
    @(posedge core_clk);
    xram_wr <= 1'b0;
    xram_rd <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    chk("oe", pin_oe, 8'h00);
    chk("pullup", {7'h0, pull_on}, 8'h01);
    chk("outs", {4'h0, t0, t1, i0, i1}, 8'h00);
    sfr(1'b0, UIO_SFR_DATA, 8'h00);
    chk("pulled pins", sfr_rdata, 8'hff);
    for (int i = 0; i < 4; i++) begin
      xr(1'b0, UIO_XR_ROUTE_A + 16'(i), 8'h00);
      chk("route reset", xram_rdata, 8'h00);
    end
  endtask

  task automatic t_dir_data();
    sfr(1'b1, UIO_SFR_DIR, 8'h0f);
    chk("oe", pin_oe, 8'hf0);
    chk("pullup off", {7'h0, pull_on}, 8'h00);
    @(posedge core_clk);
    ext_en <= 8'hff;
    ext_val <= 8'h03;
    sfr(1'b1, UIO_SFR_DATA, 8'ha5);
    chk("pin out", pin_out, 8'ha5);
    cyc(4);
    sfr(1'b0, UIO_SFR_DATA, 8'h00);
    chk("data read", sfr_rdata, 8'ha3);
    sfr(1'b0, 8'h92, 8'h00);
    chk("unmapped", sfr_rdata, 8'h00);
    sfr(1'b0, UIO_SFR_DIR, 8'h00);
    chk("dir read", sfr_rdata, 8'h0f);
  endtask

  // every select code on pins 0 and 1 together at both levels, level mode
  task automatic t_route();
    logic [3:0] e;
    xr(1'b1, UIO_XR_ROUTE_A, 8'hff);
    xr(1'b0, UIO_XR_ROUTE_A, 8'h00);
    chk("route mask", xram_rdata, 8'h77);
    xr(1'b1, UIO_XR_ROUTE_B, 8'h22);
    xr(1'b0, UIO_XR_ROUTE_B, 8'h00);
    chk("route b", xram_rdata, 8'h22);
    for (int s = 0; s < 8; s++) begin
      for (int l = 0; l < 2; l++) begin
        xr(1'b1, UIO_XR_ROUTE_A, {1'b0, 3'(s), 1'b0, 3'(s)});
        @(posedge core_clk);
        ext_val[1:0] <= {2{l[0]}};
        cyc(4);
        e = {s == 2 && l == 1, s == 3 && l == 1,
             (s == 4 && l == 1) || (s == 6 && l == 0),
             (s == 5 && l == 1) || (s == 7 && l == 0)};
        chk("routed", {4'h0, t0, t1, i0, i1}, {4'h0, e});
      end
    end
    xr(1'b1, UIO_XR_ROUTE_A, 8'h00);
    @(posedge core_clk);
    ext_val <= 8'h08;
    cyc(4);
    chk("or merge", {7'h0, t0}, 8'h01);
    @(posedge core_clk);
    ext_val <= 8'h00;
    cyc(4);
    chk("or merge", {7'h0, t0}, 8'h00);
  endtask

  // a rising routed level in edge mode gives exactly one pulse
  task automatic t_edge(input logic [7:0] rt, input int b, input logic k);
    logic [7:0] hi;
    hi = 8'h00;
    xr(1'b1, UIO_XR_ROUTE_A, rt);
    @(posedge core_clk);
    ext_val[b] <= 1'b1;
    repeat (6) begin
      cyc(1);
      hi = hi + {7'h0, k ? i1 : i0};
    end
    chk("edge pulses", hi, 8'h01);
  endtask

  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(3);
    t_reset();
    t_dir_data();
    t_route();
    @(posedge core_clk);
    it0 <= 1'b1;
    it1 <= 1'b1;
    t_edge(8'h04, 0, 1'b0);
    t_edge(8'h50, 1, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
